// ==== acr_pkg.sv ====
// shared constants for the amplifier control and calibration register bank
`default_nettype none
package acr_pkg;

    localparam int ADDR_W = 4;

    // byte offsets on the apb bus, one aligned word each
    localparam logic [3:0] AMP0_CONTROL_OFS     = 4'h0;
    localparam logic [3:0] AMP1_CONTROL_OFS     = 4'h4;
    localparam logic [3:0] AMP0_OFFSET_TRIM_OFS = 4'h8;
    localparam logic [3:0] AMP1_OFFSET_TRIM_OFS = 4'hc;

    // control register field positions
    localparam int CTL_ON_BIT   = 6;
    localparam int CTL_FLAG_BIT = 5;
    localparam int CTL_BW_LSB   = 0;
    localparam int CTL_BW_W     = 2;

    // offset trim register field positions
    localparam int TRIM_MODE_BIT = 7;
    localparam int TRIM_REF_BIT  = 6;
    localparam int TRIM_CODE_LSB = 0;
    localparam int TRIM_CODE_W   = 6;

    // writable bits of the control register
    localparam logic [7:0] CTL_WR_MASK = 8'h43;

    // values after reset
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h20;

    // bandwidth codes
    typedef enum logic [1:0] {
        ACR_BW_5K   = 2'h0,
        ACR_BW_40K  = 2'h1,
        ACR_BW_600K = 2'h2,
        ACR_BW_2M   = 2'h3
    } acr_bw_e;

    localparam int SYNC_STAGES = 2;

endpackage : acr_pkg
`default_nettype wire

// ==== acr_sync.sv ====
// two-flop level synchroniser for one asynchronous bit
`timescale 1ns/1ns
`default_nettype none
module acr_sync (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic async_i,
    output var  logic sync_o
);
    logic meta_reg;

    // first stage is read by the second stage only
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            meta_reg <= 1'b0;
            sync_o   <= 1'b0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : acr_sync
`default_nettype wire

// ==== acr_amp_regs.sv ====
// one amplifier's control and offset trim registers
`timescale 1ns/1ns
`default_nettype none
module acr_amp_regs (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ctl_wr_i,
    input  wire logic       trim_wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       amp_out_sync_i,
    output var  logic [7:0] ctl_rd_o,
    output var  logic [7:0] trim_reg_o,
    output var  logic       on_o,
    output var  logic [1:0] bw_o,
    output var  logic       flag_o
);
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [7:0] trim_next;
    logic       cal_mode;
    logic       flag_reg;
    logic       flag_next;

    // only enable and bandwidth bits are stored; others stay zero
    assign ctl_next  = ctl_wr_i ? (wdata_i & acr_pkg::CTL_WR_MASK) : ctl_reg; // see RQ1 // see RQ5 // see RQ10
    assign trim_next = trim_wr_i ? wdata_i : trim_reg_o;                       // see RQ7 // see RQ8 // see RQ9
    assign cal_mode  = trim_reg_o[acr_pkg::TRIM_MODE_BIT];
    // status follows output only in calibration mode, else fixed low
    assign flag_next = cal_mode & amp_out_sync_i;                              // see RQ3 // see RQ4

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ctl_reg    <= acr_pkg::CTL_RESET;
            trim_reg_o <= acr_pkg::TRIM_RESET;
            flag_reg   <= 1'b0;
        end
        else
        begin
            ctl_reg    <= ctl_next;
            trim_reg_o <= trim_next;
            flag_reg   <= flag_next;
        end
    end

    // status bit is never written from the bus
    assign ctl_rd_o = {1'b0, ctl_reg[acr_pkg::CTL_ON_BIT], flag_reg, 3'h0,
                       ctl_reg[acr_pkg::CTL_BW_LSB +: acr_pkg::CTL_BW_W]}; // see RQ2 // see RQ10
    assign on_o     = ctl_reg[acr_pkg::CTL_ON_BIT];
    assign bw_o     = ctl_reg[acr_pkg::CTL_BW_LSB +: acr_pkg::CTL_BW_W];
    assign flag_o   = flag_reg;
endmodule : acr_amp_regs
`default_nettype wire

// ==== acr_top.sv ====
// apb register bank controlling two calibrated amplifiers
//
// Behaviour
// RQ1 - each control register bit 6 is a writable amplifier enable, reset to zero.
// RQ2 - control bit 5 is a read-only output status bit that ignores writes and resets to zero.
// RQ3 - in calibration mode the status bit shows the amplifier output, high reads as one.
// RQ4 - outside calibration mode the status bit always reads zero.
// RQ5 - control bits 1 to 0 are a writable bandwidth code reset to 00: 5k, 40k, 600k, 2M.
// RQ6 - the second amplifier has the same bandwidth, enable and status layout.
// RQ7 - offset register bit 7 selects calibration mode, reset to zero.
// RQ8 - offset register bit 6 selects positive (1) or negative (0) reference pin, reset zero.
// RQ9 - offset register bits 5 to 0 are a 6-bit trim code reset to 100000.
// RQ10 - control bits 7 and 4 to 2 read zero and ignore writes.
// RQ11 - software calibrates by setting mode and reference, then stepping trim up from 000000.
// RQ12 - software then steps down from 111111 and writes back the truncated average.
// RQ13 - each amplifier output is synchronised by two flops before it reaches its status bit.
`timescale 1ns/1ns
`default_nettype none
module acr_top #(
    parameter int NUM_AMPS = 2
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESETN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output var  logic        PREADY_O,
    output var  logic [31:0] PRDATA_O,
    output var  logic        PSLVERR_O,
    input  wire logic        AMP0_OUT_I,
    input  wire logic        AMP1_OUT_I,
    output var  logic        AMP0_ON_O,
    output var  logic        AMP1_ON_O,
    output var  logic [1:0]  AMP0_BANDWIDTH_CODE_O,
    output var  logic [1:0]  AMP1_BANDWIDTH_CODE_O,
    output var  logic        AMP0_CAL_MODE_O,
    output var  logic        AMP1_CAL_MODE_O,
    output var  logic        AMP0_CAL_REF_SELECT_O,
    output var  logic        AMP1_CAL_REF_SELECT_O,
    output var  logic [5:0]  AMP0_TRIM_CODE_O,
    output var  logic [5:0]  AMP1_TRIM_CODE_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        access_phase;
    logic        wr_en;
    logic        addr_ok;
    logic        aligned;
    logic        hit_ctl0;
    logic        hit_ctl1;
    logic        hit_trim0;
    logic        hit_trim1;
    logic        lane0;
    logic [3:0]  ofs;
    logic [7:0]  wbyte;

    assign ofs          = PADDR_I[acr_pkg::ADDR_W-1:0];
    assign aligned      = (PADDR_I[31:acr_pkg::ADDR_W] == 28'h0000000);
    assign hit_ctl0     = aligned && (ofs == acr_pkg::AMP0_CONTROL_OFS);
    assign hit_ctl1     = aligned && (ofs == acr_pkg::AMP1_CONTROL_OFS);
    assign hit_trim0    = aligned && (ofs == acr_pkg::AMP0_OFFSET_TRIM_OFS);
    assign hit_trim1    = aligned && (ofs == acr_pkg::AMP1_OFFSET_TRIM_OFS);
    assign addr_ok      = hit_ctl0 | hit_ctl1 | hit_trim0 | hit_trim1;
    // one wait state: answer comes in the second access cycle
    assign access_phase = PSEL_I && PENABLE_I && !PREADY_O;
    // only byte lane 0 holds data; upper lanes are ignored
    assign lane0        = PSTRB_I[0];
    assign wr_en        = access_phase && PWRITE_I && addr_ok && lane0;
    assign wbyte        = PWDATA_I[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // amplifier register slices

    logic [NUM_AMPS-1:0] amp_async;
    logic [NUM_AMPS-1:0] amp_sync;
    logic [NUM_AMPS-1:0] ctl_wr;
    logic [NUM_AMPS-1:0] trim_wr;
    logic [7:0]          ctl_rd  [NUM_AMPS];
    logic [7:0]          trim_rd [NUM_AMPS];
    logic [NUM_AMPS-1:0] amp_on;
    logic [1:0]          amp_bw  [NUM_AMPS];

    assign amp_async = {AMP1_OUT_I, AMP0_OUT_I};
    assign ctl_wr    = {wr_en & hit_ctl1, wr_en & hit_ctl0};
    assign trim_wr   = {wr_en & hit_trim1, wr_en & hit_trim0};

    // identical slice per amplifier keeps the two layouts the same
    for (genvar i = 0; i < NUM_AMPS; i++)
    begin : g_amp
        acr_sync u_sync (                          // see RQ13
            .clk_i    (CLK_SYS_I),
            .resetn_i (RESETN_I),
            .async_i  (amp_async[i]),
            .sync_o   (amp_sync[i])
        );
        acr_amp_regs u_regs (                      // see RQ6
            .clk_i          (CLK_SYS_I),
            .resetn_i       (RESETN_I),
            .ctl_wr_i       (ctl_wr[i]),
            .trim_wr_i      (trim_wr[i]),
            .wdata_i        (wbyte),
            .amp_out_sync_i (amp_sync[i]),
            .ctl_rd_o       (ctl_rd[i]),
            .trim_reg_o     (trim_rd[i]),
            .on_o           (amp_on[i]),
            .bw_o           (amp_bw[i]),
            .flag_o         ()
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux and response

    logic [7:0]  rd_byte;
    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;

    assign rd_byte      = hit_ctl0  ? ctl_rd[0]  :
                          hit_ctl1  ? ctl_rd[1]  :
                          hit_trim0 ? trim_rd[0] :
                          hit_trim1 ? trim_rd[1] : 8'h00;
    assign pready_next  = access_phase;
    assign pslverr_next = access_phase && !addr_ok;
    assign prdata_next  = (access_phase && !PWRITE_I) ? {24'h000000, rd_byte} : 32'h00000000;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RESETN_I)
        begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h00000000;
        end
        else
        begin
            PREADY_O  <= pready_next;
            PSLVERR_O <= pslverr_next;
            PRDATA_O  <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered analog control outputs, one cycle behind the register

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RESETN_I)
        begin
            AMP0_ON_O             <= 1'b0;
            AMP1_ON_O             <= 1'b0;
            AMP0_BANDWIDTH_CODE_O <= acr_pkg::ACR_BW_5K;
            AMP1_BANDWIDTH_CODE_O <= acr_pkg::ACR_BW_5K;
            AMP0_CAL_MODE_O       <= 1'b0;
            AMP1_CAL_MODE_O       <= 1'b0;
            AMP0_CAL_REF_SELECT_O <= 1'b0;
            AMP1_CAL_REF_SELECT_O <= 1'b0;
            AMP0_TRIM_CODE_O      <= acr_pkg::TRIM_RESET[5:0];
            AMP1_TRIM_CODE_O      <= acr_pkg::TRIM_RESET[5:0];
        end
        else
        begin
            AMP0_ON_O             <= amp_on[0];                     // see RQ1
            AMP1_ON_O             <= amp_on[1];
            AMP0_BANDWIDTH_CODE_O <= amp_bw[0];                     // see RQ5
            AMP1_BANDWIDTH_CODE_O <= amp_bw[1];
            AMP0_CAL_MODE_O       <= trim_rd[0][acr_pkg::TRIM_MODE_BIT];
            AMP1_CAL_MODE_O       <= trim_rd[1][acr_pkg::TRIM_MODE_BIT];
            AMP0_CAL_REF_SELECT_O <= trim_rd[0][acr_pkg::TRIM_REF_BIT]; // see RQ8
            AMP1_CAL_REF_SELECT_O <= trim_rd[1][acr_pkg::TRIM_REF_BIT];
            AMP0_TRIM_CODE_O      <= trim_rd[0][acr_pkg::TRIM_CODE_LSB +: acr_pkg::TRIM_CODE_W];
            AMP1_TRIM_CODE_O      <= trim_rd[1][acr_pkg::TRIM_CODE_LSB +: acr_pkg::TRIM_CODE_W];
        end
    end

endmodule : acr_top
`default_nettype wire

// ==== acr_amp_model.sv ====
// behavioural amplifier whose comparator output flips at a fixed trim code
`timescale 1ns/1ns
`default_nettype none
module acr_amp_model #(
    parameter logic [5:0] THRESH = 6'h10
) (
    input  wire logic       clk_i,
    input  wire logic       on_i,
    input  wire logic [5:0] trim_i,
    output var  logic       out_o
);
    // a disabled amplifier gives no usable level, so it wanders every cycle
    always_ff @(posedge clk_i)
    begin
        out_o <= on_i ? (trim_i >= THRESH) : (out_o !== 1'b1);
    end
endmodule : acr_amp_model
`default_nettype wire

// ==== acr_top_chk.sv ====
// port assertions for the amplifier register bank
`timescale 1ns/1ns
`default_nettype none
module acr_top_chk (
    input wire logic        CLK_SYS_I,
    input wire logic        RESETN_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    input wire logic        PREADY_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PSLVERR_O,
    input wire logic        AMP0_ON_O,
    input wire logic        AMP0_CAL_MODE_O,
    input wire logic [5:0]  AMP0_TRIM_CODE_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESETN_I);
    wire logic ok_a  = PADDR_I[31:4] == 28'h0 && PADDR_I[1:0] == 2'h0;
    // a write without lane 0 strobe is ignored by the slave, with no error response
    wire logic acc_w = PREADY_O && PWRITE_I && ok_a && PSTRB_I[0];
    wire logic wr_c0 = acc_w && PADDR_I[3:0] == 4'h0;
    wire logic rd_c0 = PREADY_O && !PWRITE_I && PADDR_I == 32'h0;
    ////////////////////////////////////////////////////////////////////////
    AST_RDY_LAT: assert property ($rose(PENABLE_I) |=> PREADY_O)
        else $error("no ready in second access cycle");
    AST_RDY_ONE: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    AST_ERR_MAP: assert property (PREADY_O |-> PSLVERR_O == !ok_a)
        else $error("wrong error response");
    AST_CTL_PAD: assert property (PREADY_O && !PWRITE_I && PADDR_I[31:3] == 29'h0
        |-> (PRDATA_O & 32'hffffff9c) == 32'h0) else $error("unused control bits set");
    AST_FLAG_OFF: assert property (rd_c0 && !AMP0_CAL_MODE_O && !$past(AMP0_CAL_MODE_O)
        && !$past(AMP0_CAL_MODE_O, 2) |-> !PRDATA_O[5]) else $error("status not gated");
    AST_TRIM_WR: assert property (acc_w && PADDR_I[3:0] == 4'h8 |=>
        AMP0_TRIM_CODE_O == $past(PWDATA_I[5:0]) && AMP0_CAL_MODE_O == $past(PWDATA_I[7]))
        else $error("trim write not applied");
    AST_ON_WR: assert property (wr_c0 |=> AMP0_ON_O == $past(PWDATA_I[6]))
        else $error("enable write not applied");
    AST_ON_HOLD: assert property ($changed(AMP0_ON_O) |-> wr_c0 || $past(wr_c0))
        else $error("enable changed without write");
    COV_FLAG: cover property (rd_c0 && PRDATA_O[5]);
    COV_ERR: cover property (PREADY_O && PSLVERR_O);
    COV_TRIM: cover property (acc_w && PADDR_I[3:0] == 4'h8);
endmodule : acr_top_chk
////////////////////////////////////////////////////////////////////////////
bind acr_top acr_top_chk acr_top_chk_i (
    .CLK_SYS_I        (CLK_SYS_I),
    .RESETN_I         (RESETN_I),
    .PENABLE_I        (PENABLE_I),
    .PWRITE_I         (PWRITE_I),
    .PADDR_I          (PADDR_I),
    .PWDATA_I         (PWDATA_I),
    .PSTRB_I          (PSTRB_I),
    .PREADY_O         (PREADY_O),
    .PRDATA_O         (PRDATA_O),
    .PSLVERR_O        (PSLVERR_O),
    .AMP0_ON_O        (AMP0_ON_O),
    .AMP0_CAL_MODE_O  (AMP0_CAL_MODE_O),
    .AMP0_TRIM_CODE_O (AMP0_TRIM_CODE_O)
);
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the amplifier register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, (g), (x)); end end
module tb;
    localparam logic [5:0] TH0 = 6'h17;
    localparam logic [5:0] TH1 = 6'h28;
    logic        CLK_SYS_I = 1'b0;
    logic        RESETN_I = 1'b0;
    logic        PSEL_I = 1'b0;
    logic        PENABLE_I = 1'b0;
    logic        PWRITE_I = 1'b0;
    logic [31:0] PADDR_I = 32'h0;
    logic [31:0] PWDATA_I = 32'h0;
    logic [3:0]  PSTRB_I = 4'h0;
    logic [31:0] PRDATA_O, r;
    logic        PREADY_O, PSLVERR_O, AMP0_OUT_I, AMP1_OUT_I, AMP0_ON_O, AMP1_ON_O, e;
    logic        AMP0_CAL_MODE_O, AMP1_CAL_MODE_O, AMP0_CAL_REF_SELECT_O, AMP1_CAL_REF_SELECT_O;
    logic [1:0]  AMP0_BANDWIDTH_CODE_O, AMP1_BANDWIDTH_CODE_O;
    logic [5:0]  AMP0_TRIM_CODE_O, AMP1_TRIM_CODE_O;
    int          mismatches = 0;
    int          compares = 0;
    acr_top acr_top_i (.*);
    acr_amp_model #(.THRESH(TH0)) acr_amp_model_0_i (.clk_i(CLK_SYS_I), .on_i(AMP0_ON_O),
        .trim_i(AMP0_TRIM_CODE_O), .out_o(AMP0_OUT_I));
    acr_amp_model #(.THRESH(TH1)) acr_amp_model_1_i (.clk_i(CLK_SYS_I), .on_i(AMP1_ON_O),
        .trim_i(AMP1_TRIM_CODE_O), .out_o(AMP1_OUT_I));
    initial forever #4 CLK_SYS_I = ~CLK_SYS_I;
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
        input logic [3:0] s);
        int n;
        @(posedge CLK_SYS_I);
        PSEL_I    <= 1'b1;
        PWRITE_I  <= w;
        PADDR_I   <= a;
        PWDATA_I  <= {24'h0, d};
        // strobes stay low on reads
        PSTRB_I   <= w ? s : 4'h0;
        @(posedge CLK_SYS_I);
        PENABLE_I <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK_SYS_I);
            n++;
        end
        while (PREADY_O !== 1'b1 && n < 20);
        if (n == 20) `CHK(PREADY_O, 1'b1)
        r = PRDATA_O;
        e = PSLVERR_O;
        PSEL_I    <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'hf);
        `CHK(e, 1'b0)
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [7:0] x);
        xfer(1'b0, a, 8'h0, 4'hf);
        `CHK(r, {24'h0, x})
        `CHK(e, 1'b0)
    endtask : rd
    task automatic chk_rst();
        for (int i = 0; i < 4; i++)
            rd(32'(4 * i), i > 1 ? 8'h20 : 8'h00);
        `CHK({AMP0_ON_O, AMP1_ON_O, AMP0_BANDWIDTH_CODE_O, AMP1_BANDWIDTH_CODE_O, AMP0_CAL_MODE_O,
            AMP1_CAL_MODE_O, AMP0_CAL_REF_SELECT_O, AMP1_CAL_REF_SELECT_O}, 10'h000)
        `CHK({AMP0_TRIM_CODE_O, AMP1_TRIM_CODE_O}, 12'h820)
    endtask : chk_rst
    // software offset search: up from zero, down from full scale, keep the mean
    task automatic cal(input logic [31:0] ca, input logic [31:0] ta, input logic [5:0] th);
        logic [5:0] t;
        logic [6:0] v;
        int         n;
        v = 7'h0;
        for (int p = 0; p < 2; p++)
        begin
            t = p ? 6'h3f : 6'h0;
            for (n = 0; n < 64; n++)
            begin
                wr(ta, {2'h3, t});
                repeat (4) @(posedge CLK_SYS_I); // sync stages plus amplifier delay
                xfer(1'b0, ca, 8'h0, 4'hf);
                if (n == 0) `CHK(r[5], p[0])
                if (r[5] !== p[0]) break;
                t = p ? t - 6'h1 : t + 6'h1;
            end
            v = v + {1'b0, t};
        end
        wr(ta, {2'h3, v[6:1]});
        rd(ta, {2'h3, th - 6'h1});
    endtask : cal
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge CLK_SYS_I);
        RESETN_I <= 1'b1;
        chk_rst();
        wr(32'h0, 8'hff);
        wr(32'h4, 8'hff);
        rd(32'h0, 8'h43);
        rd(32'h4, 8'h43);
        for (int b = 0; b < 4; b++)
        begin
            wr(32'h0, {6'h10, b[1:0]});
            wr(32'h4, {6'h10, b[1:0]});
            rd(32'h4, {6'h10, b[1:0]});
            `CHK({AMP0_BANDWIDTH_CODE_O, AMP1_BANDWIDTH_CODE_O}, {2{b[1:0]}})
        end
        `CHK({AMP0_ON_O, AMP1_ON_O}, 2'h3)
        wr(32'h8, 8'h5a);
        wr(32'hc, 8'ha5);
        rd(32'h8, 8'h5a);
        `CHK({AMP0_CAL_MODE_O, AMP0_CAL_REF_SELECT_O, AMP0_TRIM_CODE_O}, 8'h5a)
        `CHK({AMP1_CAL_MODE_O, AMP1_CAL_REF_SELECT_O, AMP1_TRIM_CODE_O}, 8'ha5)
        xfer(1'b1, 32'hc, 8'h00, 4'h0);
        `CHK(e, 1'b0)
        rd(32'hc, 8'ha5);
        xfer(1'b1, 32'h0, 8'h00, 4'h0);
        `CHK(e, 1'b0)
        rd(32'h0, 8'h43);
        xfer(1'b1, 32'h10, 8'hff, 4'hf);
        `CHK(e, 1'b1)
        xfer(1'b0, 32'h2, 8'h0, 4'hf);
        `CHK({e, r}, {1'b1, 32'h0})
        wr(32'h8, 8'h3f);
        repeat (4) @(posedge CLK_SYS_I);
        rd(32'h0, 8'h43);
        wr(32'h8, 8'hbf);
        repeat (4) @(posedge CLK_SYS_I);
        rd(32'h0, 8'h63);
        wr(32'h0, 8'h43);
        rd(32'h0, 8'h63);
        cal(32'h0, 32'h8, TH0);
        cal(32'h4, 32'hc, TH1);
        RESETN_I <= 1'b0;
        repeat (5) @(posedge CLK_SYS_I);
        RESETN_I <= 1'b1;
        chk_rst();
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge CLK_SYS_I);
        `CHK(1'b0, 1'b1)
        finish_test();
    end
endmodule : tb
`default_nettype wire
